// file: rtl/setpoint_defs.svh
// Constants of the setpoint detection block: sizes, reset values and encodings.
`ifndef SETPOINT_DEFS_SVH
`define SETPOINT_DEFS_SVH

// ==========================================================================
// Sizes
`define SP_COUNT 16
`define SP_INDEX_W 4
`define SP_WORD_W 16
`define SP_SLOT_COUNT 4
`define SP_SLOT_W 2

// ==========================================================================
// Reset values
`define SP_WORD_RESET 16'h0000
`define SP_FLAGS_RESET 16'h0000

// ==========================================================================
// Output slot numbers
`define SP_SLOT_DAC0 2'h0
`define SP_SLOT_DAC1 2'h1
`define SP_SLOT_TIMER0 2'h2
`define SP_SLOT_TIMER1 2'h3

`endif

// file: rtl/setpoint_pkg.sv
// Types shared by the setpoint detection block and its setpoint table.
package setpoint_pkg;

	// ==========================================================================
	// Compare criteria
	typedef enum logic [2:0] {
		crit_inside = 3'b000,
		crit_outside = 3'b001,
		crit_greater = 3'b010,
		crit_less = 3'b011,
		crit_equal = 3'b100,
		crit_hysteresis = 3'b101
	} criterion_type;

	// ==========================================================================
	// Update modes, output targets and trigger kinds
	typedef enum logic {
		upd_true_only = 1'b0,
		upd_true_false = 1'b1
	} update_type;

	typedef enum logic [2:0] {
		tgt_none = 3'b000,
		tgt_dac0 = 3'b001,
		tgt_dac1 = 3'b010,
		tgt_timer0 = 3'b011,
		tgt_timer1 = 3'b100
	} target_type;

	typedef enum logic [1:0] {
		trig_immediate = 2'b00,
		trig_analog = 2'b01,
		trig_ttl = 2'b10,
		trig_other = 2'b11
	} trigger_type;

	// ==========================================================================
	// One programmed setpoint
	typedef struct packed {
		criterion_type criterion;
		update_type update;
		target_type target;
		logic [15:0] upper;
		logic [15:0] lower;
		logic [15:0] value_true;
		logic [15:0] value_false;
	} setpoint_entry_type;

endpackage

// file: rtl/setpoint_table_if.sv
// Carrier between the detector and its setpoint table.
`timescale 1ns/10ps
`default_nettype none
interface setpoint_table_if;
	logic wr_en;
	logic [3:0] wr_idx;
	setpoint_pkg::setpoint_entry_type wr_entry;
	logic [3:0] rd_idx;
	setpoint_pkg::setpoint_entry_type rd_entry;

	modport table_side (input wr_en, input wr_idx, input wr_entry, input rd_idx, output rd_entry);
	modport user_side (output wr_en, output wr_idx, output wr_entry, output rd_idx, input rd_entry);
endinterface
`default_nettype wire

// file: rtl/setpoint_table.sv
// Storage of the sixteen programmed setpoints with a registered read port.
`timescale 1ns/10ps
`default_nettype none
`include "setpoint_defs.svh"
module setpoint_table (
	input wire logic clk,
	input wire logic rst,
	setpoint_table_if.table_side port
);
	setpoint_pkg::setpoint_entry_type entry [`SP_COUNT];
	setpoint_pkg::setpoint_entry_type read_data;

	// ==========================================================================
	// One write decoder per entry
	genvar i;
	generate
		for (i = 0; i < `SP_COUNT; i++) begin : g_entry
			always_ff @(posedge clk) begin
				if (rst) begin
					entry[i] <= '0;
				end else if (port.wr_en && port.wr_idx == `SP_INDEX_W'(i)) begin
					entry[i] <= port.wr_entry;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (rst) begin
			read_data <= '0;
		end else begin
			read_data <= entry[port.rd_idx];
		end
	end

	assign port.rd_entry = read_data;
endmodule
`default_nettype wire

// file: rtl/scan_setpoint_detector.sv
// Setpoint detection for scan samples, with per-channel detect flags and output updates.
//
// What this block does
// R1 - Each sample of a channel with a setpoint is compared, giving its own detect flag.
// R2 - Detect flag is 1 while the criterion holds and 0 while it does not.
// R3 - Inside window: true when sample below upper and above lower, both strict.
// R4 - Outside window: true when sample above upper or below lower.
// R5 - Greater than: true when sample above lower; upper unused.
// R6 - Less than: true when sample below upper; lower unused.
// R7 - Equal to: true when sample equals upper; meant for counter or digital sources.
// R8 - True-only mode writes the first value when true, nothing when false.
// R9 - True-and-false mode writes first value when true, second value when false.
// R10 - Hysteresis: above upper forces second value, below lower forces first value.
// R11 - Hysteresis leaves the detect flag unchanged between the thresholds.
// R12 - Flags are evaluated and updated at most once per scan.
// R13 - Detect flags are returned in the scan like any input channel.
// R14 - One setpoint per channel, at most sixteen per scan group.
// R15 - Counter low and high words are separate channels, each with its own setpoint.
// R16 - Software programs thresholds, criterion and mode before acquisition.
// R17 - Each setpoint targets nothing, a DAC or a timer, holding two output values.
// R18 - With other trigger kinds, evaluation starts as soon as acquisition is armed.
// R19 - Status word holds all setpoint states, setpoint 0 in the lowest bit.
// R20 - Several true setpoints on one output leave the most recently true one's value.
// R21 - An output is written only in the scan where the condition changes; the code also counts the first evaluation after arming as a change.
`timescale 1ns/10ps
`default_nettype none
`include "setpoint_defs.svh"
module scan_setpoint_detector #(
	parameter int NUM_CHANNELS = 16,
	parameter int CHANNEL_W = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic cfg_write,
	input wire logic [3:0] cfg_index,
	input wire setpoint_pkg::criterion_type cfg_criterion,
	input wire setpoint_pkg::update_type cfg_update,
	input wire setpoint_pkg::target_type cfg_target,
	input wire logic [15:0] cfg_upper,
	input wire logic [15:0] cfg_lower,
	input wire logic [15:0] cfg_value_true,
	input wire logic [15:0] cfg_value_false,
	input wire logic acq_armed,
	input wire setpoint_pkg::trigger_type acq_trigger_kind,
	input wire logic acq_triggered,
	input wire logic scan_start,
	input wire logic sample_valid,
	input wire logic [CHANNEL_W-1:0] sample_channel,
	input wire logic [15:0] sample_word,
	input wire logic sample_has_setpoint,
	input wire logic [3:0] sample_setpoint,
	output logic result_valid,
	output logic [CHANNEL_W-1:0] result_channel,
	output logic result_detect,
	output logic [NUM_CHANNELS-1:0] channel_detect_flag,
	output logic [15:0] setpoint_status,
	output logic evaluating,
	output logic [`SP_SLOT_COUNT-1:0] out_write,
	output logic [`SP_SLOT_COUNT*`SP_WORD_W-1:0] out_value
);

	// ==========================================================================
	// Parameter checks
	generate
		// Every detect flag must be addressed by a channel number of its own.
		if (NUM_CHANNELS < 1 || NUM_CHANNELS > (1 << CHANNEL_W)) begin : g_bad_channels
			$error("NUM_CHANNELS does not fit CHANNEL_W");
		end
		// A channel number wider than a sample word cannot be carried through the scan.
		if (CHANNEL_W < 1 || CHANNEL_W > `SP_WORD_W) begin : g_bad_channel_w
			$error("CHANNEL_W out of range");
		end
		// The setpoint index and the status word are fixed by the sixteen table entries.
		if (`SP_COUNT != (1 << `SP_INDEX_W)) begin : g_bad_index_w
			$error("SP_INDEX_W does not match SP_COUNT");
		end
		if (`SP_SLOT_COUNT != (1 << `SP_SLOT_W)) begin : g_bad_slot_w
			$error("SP_SLOT_W does not match SP_SLOT_COUNT");
		end
	endgenerate

	// ==========================================================================
	// State
	typedef struct packed {
		// Detect state of each setpoint, which is also the status word.
		logic [15:0] flags;
		// Set once a setpoint has been judged since arming.
		logic [15:0] primed;
		// Set once a setpoint has been judged in the current scan.
		logic [15:0] seen;
		logic [NUM_CHANNELS-1:0] chan_flags;
		// Sample stage, in step with the table read for the same sample.
		logic s1_valid;
		logic s1_has_setpoint;
		logic [3:0] s1_index;
		logic [CHANNEL_W-1:0] s1_channel;
		logic [15:0] s1_word;
		// Result stage, seen by the scan one cycle after the sample stage.
		logic res_valid;
		logic [CHANNEL_W-1:0] res_channel;
		logic res_detect;
		logic eval_on;
		// Output update slots, one word for each DAC or timer.
		logic [`SP_SLOT_COUNT-1:0] wr;
		logic [`SP_SLOT_COUNT*`SP_WORD_W-1:0] val;
	} state_type;

	state_type state;
	state_type next_state;

	setpoint_table_if table_port ();

	// The table answers one cycle after the index, in step with the sample stage.
	setpoint_table u_table (
		.clk(clk),
		.rst(rst),
		.port(table_port)
	);

	// Programming is refused while armed so that the table cannot shift under a running scan.
	assign table_port.wr_en = cfg_write && !acq_armed; // R16
	assign table_port.wr_idx = cfg_index;
	assign table_port.wr_entry = '{
		criterion: cfg_criterion,
		update: cfg_update,
		target: cfg_target,
		upper: cfg_upper,
		lower: cfg_lower,
		value_true: cfg_value_true,
		value_false: cfg_value_false
	};
	assign table_port.rd_idx = sample_setpoint;

	// ==========================================================================
	// Decoding helpers
	function automatic logic criterion_met(
		input setpoint_pkg::setpoint_entry_type e,
		input logic [15:0] x
	);
		logic met;
		met = 1'b0;
		case (e.criterion)
			setpoint_pkg::crit_inside: met = (x < e.upper) && (x > e.lower); // R3
			setpoint_pkg::crit_outside: met = (x > e.upper) || (x < e.lower); // R4
			setpoint_pkg::crit_greater: met = x > e.lower; // R5
			setpoint_pkg::crit_less: met = x < e.upper; // R6
			setpoint_pkg::crit_equal: met = x == e.upper; // R7
			default: met = 1'b0;
		endcase
		return met;
	endfunction

	function automatic logic target_used(input setpoint_pkg::target_type t);
		logic used;
		used = 1'b0;
		case (t)
			setpoint_pkg::tgt_dac0: used = 1'b1;
			setpoint_pkg::tgt_dac1: used = 1'b1;
			setpoint_pkg::tgt_timer0: used = 1'b1;
			setpoint_pkg::tgt_timer1: used = 1'b1;
			// Unused target codes act as no output at all.
			default: used = 1'b0;
		endcase
		return used;
	endfunction

	function automatic logic [`SP_SLOT_W-1:0] target_slot(input setpoint_pkg::target_type t);
		logic [`SP_SLOT_W-1:0] s;
		s = `SP_SLOT_DAC0;
		case (t)
			setpoint_pkg::tgt_dac0: s = `SP_SLOT_DAC0;
			setpoint_pkg::tgt_dac1: s = `SP_SLOT_DAC1;
			setpoint_pkg::tgt_timer0: s = `SP_SLOT_TIMER0;
			setpoint_pkg::tgt_timer1: s = `SP_SLOT_TIMER1;
			default: s = `SP_SLOT_DAC0;
		endcase
		return s;
	endfunction

	// Hysteresis keeps its flag between the thresholds, so the old flag comes in as well.
	function automatic logic hysteresis_flag(
		input logic above,
		input logic below,
		input logic held
	);
		logic f;
		f = held; // R11
		if (above) begin
			f = 1'b1; // R10
		end else if (below) begin
			f = 1'b0; // R10
		end
		return f;
	endfunction

	function automatic logic [15:0] update_value(
		input setpoint_pkg::setpoint_entry_type e,
		input logic hyst,
		input logic flag
	);
		logic [15:0] v;
		v = e.value_true; // R8
		if (hyst) begin
			// Above the window sets the flag, and that side drives the second value.
			v = flag ? e.value_false : e.value_true; // R10
		end else if (e.update == setpoint_pkg::upd_true_false) begin
			v = flag ? e.value_true : e.value_false; // R9
		end
		return v;
	endfunction

	// ==========================================================================
	// Evaluation
	setpoint_pkg::setpoint_entry_type entry;
	logic hyst_mode;
	logic above_upper;
	logic below_lower;
	logic cond;
	logic old_flag;
	logic new_flag;
	logic changed;
	logic do_write;
	logic [15:0] write_value;
	logic [`SP_SLOT_W-1:0] slot;
	logic accept;

	always_comb begin
		entry = table_port.rd_entry;
		hyst_mode = entry.criterion == setpoint_pkg::crit_hysteresis;
		above_upper = state.s1_word > entry.upper;
		below_lower = state.s1_word < entry.lower;
		cond = criterion_met(entry, state.s1_word);
		old_flag = state.flags[state.s1_index];
		if (hyst_mode) begin
			new_flag = hysteresis_flag(above_upper, below_lower, old_flag); // R10 R11
		end else begin
			new_flag = cond; // R2
		end
		// The first evaluation after arming counts as a change so that outputs start out defined.
		changed = (new_flag != old_flag) || !state.primed[state.s1_index]; // R21
		if (hyst_mode) begin
			// Between the thresholds nothing is forced until one side has been reached.
			do_write = changed && (above_upper || below_lower || state.primed[state.s1_index]); // R10
		end else if (entry.update == setpoint_pkg::upd_true_false) begin
			do_write = changed; // R9
		end else begin
			do_write = changed && new_flag; // R8
		end
		write_value = update_value(entry, hyst_mode, new_flag); // R8 R9 R10
		do_write = do_write && target_used(entry.target); // R17
		slot = target_slot(entry.target);
		// A second sample of the same setpoint in one scan is ignored.
		accept = state.s1_valid && state.s1_has_setpoint && !state.seen[state.s1_index]; // R12 R14
	end

	// ==========================================================================
	// Output slot decode
	wire logic [`SP_SLOT_COUNT-1:0] slot_hit;

	genvar k;
	generate
		for (k = 0; k < `SP_SLOT_COUNT; k++) begin : g_slot
			// Only one sample is judged per cycle, so at most one slot is hit.
			assign slot_hit[k] = accept && do_write && slot == `SP_SLOT_W'(k); // R20
		end
	endgenerate

	// ==========================================================================
	// Next state
	always_comb begin
		next_state = state;
		next_state.wr = '0;
		next_state.res_valid = 1'b0;
		// Immediate, analog and external triggers wait for the trigger itself before judging.
		next_state.eval_on = acq_armed &&
			(acq_trigger_kind == setpoint_pkg::trig_other || acq_triggered); // R18

		next_state.s1_valid = sample_valid && state.eval_on;
		next_state.s1_has_setpoint = sample_has_setpoint;
		next_state.s1_index = sample_setpoint;
		next_state.s1_channel = sample_channel;
		next_state.s1_word = sample_word; // R15

		if (state.s1_valid) begin
			// Every channel scanned while evaluating returns its detect flag alongside its data.
			next_state.res_valid = 1'b1; // R13
			next_state.res_channel = state.s1_channel;
			next_state.res_detect = accept ? new_flag :
				(state.s1_has_setpoint ? old_flag : 1'b0);
		end

		if (accept) begin
			next_state.seen[state.s1_index] = 1'b1; // R12
			next_state.primed[state.s1_index] = 1'b1;
			next_state.flags[state.s1_index] = new_flag; // R19
			next_state.chan_flags[state.s1_channel] = new_flag; // R1
		end

		// A channel scanned without a setpoint shows no detect, so no stale flag stays behind.
		if (state.s1_valid && !state.s1_has_setpoint) begin
			next_state.chan_flags[state.s1_channel] = 1'b0; // R1
		end

		// Samples arrive in scan order, so the latest write to a slot is the newest change.
		next_state.wr = slot_hit; // R20
		for (int n = 0; n < `SP_SLOT_COUNT; n++) begin
			if (slot_hit[n]) begin
				next_state.val[n*`SP_WORD_W +: `SP_WORD_W] = write_value; // R20
			end
		end

		// A new scan lets every setpoint be judged once more.
		if (scan_start) begin
			next_state.seen = `SP_FLAGS_RESET; // R12
		end

		// Disarming forgets scan marks and priming but keeps the flags for the status word.
		if (!acq_armed) begin
			next_state.seen = `SP_FLAGS_RESET;
			next_state.primed = `SP_FLAGS_RESET;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// ==========================================================================
	// Outputs
	// Every output is a field of the state register, so none passes through logic.
	assign result_valid = state.res_valid;
	assign result_channel = state.res_channel;
	assign result_detect = state.res_detect; // R13
	assign channel_detect_flag = state.chan_flags;
	assign setpoint_status = state.flags; // R19
	assign evaluating = state.eval_on;
	assign out_write = state.wr;
	assign out_value = state.val;

endmodule
`default_nettype wire

// file: verif/scan_setpoint_detector_props.sv
// Port-level checker of the setpoint detector, bound to its top module.
`timescale 1ns/10ps
`default_nettype none
module scan_setpoint_detector_props #(
	parameter int NUM_CHANNELS = 16,
	parameter int CHANNEL_W = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic acq_armed,
	input wire setpoint_pkg::trigger_type acq_trigger_kind,
	input wire logic sample_valid,
	input wire logic sample_has_setpoint,
	input wire logic [3:0] sample_setpoint,
	input wire logic result_valid,
	input wire logic [CHANNEL_W-1:0] result_channel,
	input wire logic result_detect,
	input wire logic [NUM_CHANNELS-1:0] channel_detect_flag,
	input wire logic [15:0] setpoint_status,
	input wire logic evaluating,
	input wire logic [3:0] out_write,
	input wire logic [63:0] out_value
);
	// ==========
	// Properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_take;
		sample_valid && evaluating;
	endsequence
	sequence s_answer;
		##2 result_valid;
	endsequence
	AST_TAKEN_ANSWER: assert property (s_take |-> s_answer)
		else $error("accepted sample gave no result");
	AST_NO_TAKE_IDLE: assert property (sample_valid && !evaluating |-> ##2 !result_valid)
		else $error("result while not evaluating");
	AST_RESULT_CAUSE: assert property (result_valid |-> $past(sample_valid, 2) && $past(evaluating, 2))
		else $error("result without a sample");
	AST_EVAL_ARMED: assert property (acq_armed && acq_trigger_kind == setpoint_pkg::trig_other |=> evaluating)
		else $error("armed but not evaluating");
	AST_EVAL_DISARM: assert property (!acq_armed |=> !evaluating)
		else $error("evaluating while disarmed");
	AST_STATUS_BIT: assert property (result_valid && $past(sample_has_setpoint, 2)
		|-> setpoint_status[$past(sample_setpoint, 2)] == result_detect)
		else $error("status bit differs from result");
	AST_FLAG_CHANNEL: assert property (result_valid |-> channel_detect_flag[result_channel] == result_detect)
		else $error("channel flag differs from result");
	AST_WRITE_WITH_RESULT: assert property (|out_write |-> result_valid)
		else $error("output write without a result");
	// Status may only move on a result while armed, so a flag cannot change faster than the scan.
	AST_STATUS_STEADY: assert property (acq_armed && $past(acq_armed) && !result_valid |-> $stable(setpoint_status))
		else $error("status changed without a result");
	AST_VALUE_HOLD: assert property (!$past(rst) && out_write == 4'h0 |-> $stable(out_value))
		else $error("output value changed without a write");
endmodule
bind scan_setpoint_detector scan_setpoint_detector_props #(.NUM_CHANNELS(NUM_CHANNELS), .CHANNEL_W(CHANNEL_W))
	scan_setpoint_detector_props_inst (.clk, .rst, .acq_armed, .acq_trigger_kind, .sample_valid, .sample_has_setpoint,
	.sample_setpoint, .result_valid, .result_channel, .result_detect, .channel_detect_flag, .setpoint_status,
	.evaluating, .out_write, .out_value);
`default_nettype wire

// file: verif/scan_sequencer_model.sv
// Scan sequencer model that presents one sample word at a time to the detector.
`timescale 1ns/10ps
`default_nettype none
module scan_sequencer_model (
	input wire logic clk,
	output logic scan_start,
	output logic sample_valid,
	output logic [3:0] sample_channel,
	output logic [15:0] sample_word,
	output logic sample_has_setpoint,
	output logic [3:0] sample_setpoint
);
	initial begin
		scan_start = 1'b0;
		sample_valid = 1'b0;
		sample_channel = 4'h0;
		sample_word = 16'h0000;
		sample_has_setpoint = 1'b0;
		sample_setpoint = 4'h0;
	end
	// ==========
	// Sample
	// The word is inverted once released, so a stale word can never pass for a fresh one.
	task automatic send(input logic s, input logic [3:0] ch, input logic [15:0] w);
		if (s) begin
			@(posedge clk);
			scan_start <= 1'b1;
		end
		@(posedge clk);
		scan_start <= 1'b0;
		sample_valid <= 1'b1;
		sample_channel <= ch;
		sample_word <= w;
		sample_has_setpoint <= 1'b1;
		sample_setpoint <= ch;
		@(posedge clk);
		sample_valid <= 1'b0;
		sample_has_setpoint <= 1'b0;
		sample_word <= ~w;
	endtask
endmodule
`default_nettype wire

// file: verif/testbench.sv
// Self-checking testbench of the setpoint detector.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic clk = 1'b0, rst = 1'b1, cfg_write = 1'b0, acq_armed = 1'b0, acq_triggered = 1'b0;
	logic [3:0] cfg_index = 4'h0;
	setpoint_pkg::criterion_type cfg_criterion = setpoint_pkg::crit_inside;
	setpoint_pkg::update_type cfg_update = setpoint_pkg::upd_true_only;
	setpoint_pkg::target_type cfg_target = setpoint_pkg::tgt_none;
	setpoint_pkg::trigger_type acq_trigger_kind = setpoint_pkg::trig_other;
	logic [15:0] cfg_upper = 16'h0000, cfg_lower = 16'h0000, cfg_value_true = 16'haaaa, cfg_value_false = 16'h5555;
	logic scan_start, sample_valid, sample_has_setpoint, result_valid, result_detect, evaluating;
	logic [3:0] sample_channel, sample_setpoint, result_channel, out_write;
	logic [15:0] sample_word, channel_detect_flag, setpoint_status;
	logic [63:0] out_value;
	int n_fail = 0, n_compared = 0, cycles = 0;
	typedef struct {setpoint_pkg::criterion_type c; logic [15:0] u, l, w; logic d;} row_type;
	row_type rows [12] = '{
		'{setpoint_pkg::crit_inside, 16'h0100, 16'h0010, 16'h0080, 1'b1},
		'{setpoint_pkg::crit_inside, 16'h0100, 16'h0010, 16'h0100, 1'b0},
		'{setpoint_pkg::crit_inside, 16'h0100, 16'h0010, 16'h0010, 1'b0},
		'{setpoint_pkg::crit_outside, 16'h0100, 16'h0010, 16'h0101, 1'b1},
		'{setpoint_pkg::crit_outside, 16'h0100, 16'h0010, 16'h0100, 1'b0},
		'{setpoint_pkg::crit_outside, 16'h0100, 16'h0010, 16'h000f, 1'b1},
		'{setpoint_pkg::crit_greater, 16'h0005, 16'h0010, 16'h0011, 1'b1},
		'{setpoint_pkg::crit_greater, 16'h0005, 16'h0010, 16'h0010, 1'b0},
		'{setpoint_pkg::crit_less, 16'h0100, 16'h0200, 16'h00ff, 1'b1},
		'{setpoint_pkg::crit_less, 16'h0100, 16'h0200, 16'h0100, 1'b0},
		'{setpoint_pkg::crit_equal, 16'h0100, 16'h0200, 16'h0100, 1'b1},
		'{setpoint_pkg::crit_equal, 16'h0100, 16'h0200, 16'h0101, 1'b0}};
	scan_setpoint_detector scan_setpoint_detector_inst (.clk, .rst, .cfg_write, .cfg_index, .cfg_criterion, .cfg_update,
		.cfg_target, .cfg_upper, .cfg_lower, .cfg_value_true, .cfg_value_false, .acq_armed, .acq_trigger_kind,
		.acq_triggered, .scan_start, .sample_valid, .sample_channel, .sample_word, .sample_has_setpoint,
		.sample_setpoint, .result_valid, .result_channel, .result_detect, .channel_detect_flag, .setpoint_status,
		.evaluating, .out_write, .out_value);
	scan_sequencer_model scan_sequencer_model_inst (.clk, .scan_start, .sample_valid, .sample_channel, .sample_word,
		.sample_has_setpoint, .sample_setpoint);
	always #4 clk = ~clk;
	// ==========
	// Tasks
	task automatic finish_test();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic cfg(input logic [3:0] i, input setpoint_pkg::criterion_type c, input setpoint_pkg::update_type m,
			input setpoint_pkg::target_type t, input logic [15:0] u, input logic [15:0] l);
		@(posedge clk);
		cfg_write <= 1'b1;
		cfg_index <= i;
		cfg_criterion <= c;
		cfg_update <= m;
		cfg_target <= t;
		cfg_upper <= u;
		cfg_lower <= l;
		@(posedge clk);
		cfg_write <= 1'b0;
	endtask
	task automatic arm(input logic on);
		@(posedge clk);
		acq_armed <= on;
		repeat (2) @(posedge clk);
	endtask
	// The result stands for one cycle, from the edge after the one at which the model drops the sample.
	task automatic look(input logic s, input logic [3:0] ch, input logic [15:0] w, input logic d,
			input logic [3:0] wr, input int k, input logic [15:0] v);
		scan_sequencer_model_inst.send(s, ch, w);
		@(posedge clk);
		#1;
		chk("valid", result_valid, 1'b1);
		chk("detect", result_detect, d);
		chk("flag", channel_detect_flag[ch], d);
		chk("channel", result_channel, ch);
		chk("status", setpoint_status[ch], d);
		chk("write", out_write, wr);
		if (wr != 4'h0)
			chk("value", out_value[k*16 +: 16], v);
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			finish_test();
		end
	end
	// ==========
	// Sequence
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk("evaluating", evaluating, 1'b0);
		chk("status", setpoint_status, 16'h0000);
		foreach (rows[n]) begin
			cfg(4'h0, rows[n].c, setpoint_pkg::upd_true_false, setpoint_pkg::tgt_dac0, rows[n].u, rows[n].l);
			arm(1'b1);
			look(1'b1, 4'h0, rows[n].w, rows[n].d, 4'h1, 0, rows[n].d ? 16'haaaa : 16'h5555);
			arm(1'b0);
		end
		acq_trigger_kind <= setpoint_pkg::trig_immediate;
		arm(1'b1);
		#1;
		chk("evaluating", evaluating, 1'b0);
		@(posedge clk);
		acq_triggered <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk("evaluating", evaluating, 1'b1);
		arm(1'b0);
		acq_triggered <= 1'b0;
		acq_trigger_kind <= setpoint_pkg::trig_other;
		cfg(4'h1, setpoint_pkg::crit_greater, setpoint_pkg::upd_true_only, setpoint_pkg::tgt_dac1, 16'h0000, 16'h0010);
		cfg(4'h2, setpoint_pkg::crit_equal, setpoint_pkg::upd_true_false, setpoint_pkg::tgt_none, 16'h0007,
			16'h0000);
		arm(1'b1);
		look(1'b1, 4'h2, 16'h0007, 1'b1, 4'h0, 0, 16'h0000);
		look(1'b1, 4'h1, 16'h0005, 1'b0, 4'h0, 1, 16'h0000);
		look(1'b1, 4'h1, 16'h0020, 1'b1, 4'h2, 1, 16'haaaa);
		look(1'b0, 4'h1, 16'h0005, 1'b1, 4'h0, 1, 16'h0000);
		cfg(4'h1, setpoint_pkg::crit_less, setpoint_pkg::upd_true_false, setpoint_pkg::tgt_dac1, 16'h0100, 16'h0000);
		look(1'b1, 4'h1, 16'h0030, 1'b1, 4'h0, 1, 16'h0000);
		look(1'b1, 4'h1, 16'h0005, 1'b0, 4'h0, 1, 16'h0000);
		arm(1'b0);
		cfg(4'h3, setpoint_pkg::crit_hysteresis, setpoint_pkg::upd_true_only, setpoint_pkg::tgt_timer0, 16'h0200,
			16'h0100);
		arm(1'b1);
		look(1'b1, 4'h3, 16'h0300, 1'b1, 4'h4, 2, 16'h5555);
		look(1'b1, 4'h3, 16'h0180, 1'b1, 4'h0, 2, 16'h0000);
		look(1'b1, 4'h3, 16'h0050, 1'b0, 4'h4, 2, 16'haaaa);
		look(1'b1, 4'h3, 16'h0180, 1'b0, 4'h0, 2, 16'h0000);
		arm(1'b0);
		scan_sequencer_model_inst.send(1'b1, 4'h3, 16'h0300);
		@(posedge clk);
		#1;
		chk("valid", result_valid, 1'b0);
		@(posedge clk);
		rst <= 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk("value", out_value, 64'h0);
		chk("status", setpoint_status, 16'h0000);
		finish_test();
	end
endmodule
`default_nettype wire
